// ===== core/txc_pkg.sv
// constants, register map and state types of the transmit controller config block
// Contract
// - wait init period before raising clock request
// - no transfers until controller-ready bit set
// - format bits pick general or accurate framing
// - polarity bits: de, hsync, vsync, zero high
// - clock mode bit picks continuous or gated
// - clock lane ultra-low-power enter and exit
// - data lanes ultra-low-power enter and exit
// - frame number off at zero, wraps to one
// - raw8/10/12 line numbering enable bits
// - eight user type line numbering enables
// - embedded data line numbering enable
// - interrupt enables for read/write commands
// - status bits set on read/write commands
// - mark-1 for wake time, then drop escape
// - periodic skew pattern during frame blanking
// - periodic skew length is twelve-bit field
// - initial skew request during initialisation
// - initial skew lasts programmed byte clocks
package txc_pkg;

  // --------------------------------------------------------------
  // register indices and map
  // --------------------------------------------------------------
  localparam int NREG = 22;
  localparam int R_INIT_HI = 0;
  localparam int R_INIT_LO = 1;
  localparam int R_ISKEW_EN = 2;
  localparam int R_ISKEW_HI = 3;
  localparam int R_ISKEW_LO = 4;
  localparam int R_READY = 5;
  localparam int R_FMT = 6;
  localparam int R_POL = 7;
  localparam int R_LANE = 8;
  localparam int R_CLKMODE = 9;
  localparam int R_FN_HI = 10;
  localparam int R_FN_LO = 11;
  localparam int R_IRQ_EN = 12;
  localparam int R_PSKEW_EN = 13;
  localparam int R_PSKEW_HI = 14;
  localparam int R_PSKEW_LO = 15;
  localparam int R_SCRAM = 16;
  localparam int R_LN_RAW = 17;
  localparam int R_LN_UDT = 18;
  localparam int R_LN_EMB = 19;
  localparam int R_WAKE_HI = 20;
  localparam int R_WAKE_LO = 21;

  localparam logic [15:0] REG_ADDR [NREG] = '{
    16'h6001, 16'h6002, 16'h6003, 16'h6004, 16'h6005, 16'h6006,
    16'h6010, 16'h6011, 16'h6012, 16'h6013, 16'h6016, 16'h6017,
    16'h6018, 16'h601c, 16'h601d, 16'h601e, 16'h601f, 16'h6037,
    16'h6038, 16'h6039, 16'h6065, 16'h6066};
  // writable bits; the rest read as zero
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h01,
    8'h03, 8'h07, 8'h01, 8'h01, 8'hff, 8'hff,
    8'h03, 8'h01, 8'h0f, 8'hff, 8'h01, 8'h07,
    8'hff, 8'h01, 8'hff, 8'hff};
  localparam logic [7:0] REG_RST [NREG] = '{
    8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h10};

  localparam logic [15:0] A_CLK_LP = 16'h6014;
  localparam logic [15:0] A_DAT_LP = 16'h6015;
  localparam logic [15:0] A_STATUS = 16'h6019;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int B_READY = 0;
  localparam int B_FMT_FRAME = 0;
  localparam int B_FMT_EMB = 1;
  localparam int B_POL_DE = 0;
  localparam int B_POL_HS = 1;
  localparam int B_POL_VS = 2;
  localparam int B_NONCONT = 0;
  localparam int B_LANE2 = 0;
  localparam int B_ENABLE = 0;
  localparam int B_LP_ENTER = 0;
  localparam int B_LP_EXIT = 1;
  localparam int LP_LANE_STRIDE = 2;
  localparam int B_CMD_RD = 0;
  localparam int B_CMD_WR = 1;

  // --------------------------------------------------------------
  // data types and line counter slots
  // --------------------------------------------------------------
  localparam logic [5:0] DT_EMB = 6'h12;
  localparam logic [5:0] DT_RAW8 = 6'h2a;
  localparam logic [5:0] DT_RAW12 = 6'h2c;
  localparam logic [5:0] DT_UDT1 = 6'h30;
  localparam logic [5:0] DT_UDT8 = 6'h37;
  localparam int N_LN = 12;
  localparam logic [3:0] LN_UDT_BASE = 4'h3;
  localparam logic [3:0] LN_EMB_SLOT = 4'hb;
  localparam int N_LANES = 3;

  typedef enum logic [3:0] {
    S_INIT = 4'b0001,
    S_RDY = 4'b0010,
    S_ISKEW = 4'b0100,
    S_RUN = 4'b1000
  } seq_state_t;

  typedef enum logic [2:0] {
    L_IDLE = 3'b001,
    L_ULPS = 3'b010,
    L_WAKE = 3'b100
  } lp_state_t;

endpackage

// ===== core/lp_lane.sv
// ultra-low-power entry/exit and wake timing for one lane
`timescale 1ns/1ps
module lp_lane (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enter_i,
  input wire logic exit_i,
  input wire logic esc_tick_i,
  input wire logic [15:0] twake_i,
  output logic esc_req_o,
  output logic ulps_o,
  output logic busy_o
);

  txc_pkg::lp_state_t st_q, st_d;
  logic [15:0] cnt_q;

  wire wake_done = (st_q == txc_pkg::L_WAKE) && esc_tick_i && (cnt_q >= twake_i);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      txc_pkg::L_IDLE: if (enter_i) st_d = txc_pkg::L_ULPS;
      txc_pkg::L_ULPS: if (exit_i) st_d = txc_pkg::L_WAKE;
      txc_pkg::L_WAKE: if (wake_done) st_d = txc_pkg::L_IDLE;
      default: st_d = txc_pkg::L_IDLE;
    endcase
  end

  // wake count in escape clock edges; mark-1 held meanwhile
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= txc_pkg::L_IDLE;
      cnt_q <= 16'h0000;
      esc_req_o <= 1'b0;
      ulps_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (st_q != txc_pkg::L_WAKE)
        cnt_q <= 16'h0000;
      else if (esc_tick_i && !wake_done)
        cnt_q <= cnt_q + 16'h0001;
      esc_req_o <= st_d != txc_pkg::L_IDLE;
      ulps_o <= st_d == txc_pkg::L_ULPS;
      busy_o <= st_d != txc_pkg::L_IDLE;
    end
  end

  property p_wake_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(esc_req_o) |-> $past(cnt_q) >= $past(twake_i);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("escape dropped early");

  property p_ulps_exit;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_q == txc_pkg::L_ULPS && exit_i) |=> (!ulps_o && esc_req_o);
  endproperty
  a_ulps_exit: assert property (p_ulps_exit) else $error("no mark-1 on exit");

endmodule

// ===== core/csi_tx_config.sv
// transmit controller configuration, sequencing and numbering
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module csi_tx_config #(
  parameter int BYTE_DIV = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic esc_clk_i,
  input wire logic de_i,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic [5:0] dtype_i,
  input wire logic cci_rd_cmd_i,
  input wire logic cci_wr_cmd_i,
  output logic hs_clk_req_o,
  output logic xfer_en_o,
  output logic frame_fmt_o,
  output logic emb_fmt_o,
  output logic two_lane_o,
  output logic clk_noncont_o,
  output logic scramble_o,
  output logic frame_start_o,
  output logic [15:0] frame_num_o,
  output logic line_start_o,
  output logic [15:0] line_num_o,
  output logic line_num_en_o,
  output logic pix_valid_o,
  output logic skew_req_o,
  output logic [2:0] esc_req_o,
  output logic [2:0] ulps_o,
  output logic cmd_irq_o
);

  // the divider counter is 16 bits wide
  if (BYTE_DIV < 1 || BYTE_DIV > 65536)
  begin : g_bad_div
    $error("BYTE_DIV must be 1 to 65536");
  end

  // --------------------------------------------------------------
  // register file
  // --------------------------------------------------------------
  logic [7:0] regs_q [txc_pkg::NREG];
  logic [txc_pkg::NREG-1:0] reg_hit;
  logic [7:0] rd_d;
  logic [1:0] stat_q;
  logic [2:0] lp_busy;
  logic [2:0] lp_ulps;

  for (genvar g = 0; g < txc_pkg::NREG; g++)
  begin : g_hit
    assign reg_hit[g] = addr_i == txc_pkg::REG_ADDR[g];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < txc_pkg::NREG; i++)
        regs_q[i] <= txc_pkg::REG_RST[i];
    end
    else
    begin
      for (int i = 0; i < txc_pkg::NREG; i++)
        if (wr_i && reg_hit[i])
          regs_q[i] <= wdata_i & txc_pkg::REG_MASK[i];
    end
  end

  wire [15:0] init_period = {regs_q[txc_pkg::R_INIT_HI], regs_q[txc_pkg::R_INIT_LO]};
  wire [15:0] iskew_len = {regs_q[txc_pkg::R_ISKEW_HI], regs_q[txc_pkg::R_ISKEW_LO]};
  wire [11:0] pskew_len = {regs_q[txc_pkg::R_PSKEW_HI][3:0], regs_q[txc_pkg::R_PSKEW_LO]};
  wire [15:0] fn_limit = {regs_q[txc_pkg::R_FN_HI], regs_q[txc_pkg::R_FN_LO]};
  wire [15:0] twake = {regs_q[txc_pkg::R_WAKE_HI], regs_q[txc_pkg::R_WAKE_LO]};
  wire ready = regs_q[txc_pkg::R_READY][txc_pkg::B_READY];
  wire iskew_en = regs_q[txc_pkg::R_ISKEW_EN][txc_pkg::B_ENABLE];
  wire pskew_en = regs_q[txc_pkg::R_PSKEW_EN][txc_pkg::B_ENABLE];
  wire [7:0] pol = regs_q[txc_pkg::R_POL];
  wire [1:0] irq_en = regs_q[txc_pkg::R_IRQ_EN][1:0];
  wire [txc_pkg::N_LN-1:0] ln_en = {regs_q[txc_pkg::R_LN_EMB][txc_pkg::B_ENABLE],
                                    regs_q[txc_pkg::R_LN_UDT],
                                    regs_q[txc_pkg::R_LN_RAW][2:0]};

  wire wr_clk_lp = wr_i && (addr_i == txc_pkg::A_CLK_LP);
  wire wr_dat_lp = wr_i && (addr_i == txc_pkg::A_DAT_LP);
  wire wr_stat = wr_i && (addr_i == txc_pkg::A_STATUS);

  // lane state readback instead of the pulse bits last written
  always_comb
  begin
    rd_d = 8'h00;
    for (int i = 0; i < txc_pkg::NREG; i++)
      if (reg_hit[i])
        rd_d = regs_q[i];
    if (addr_i == txc_pkg::A_CLK_LP)
      rd_d = {6'h00, lp_busy[0], lp_ulps[0]};
    if (addr_i == txc_pkg::A_DAT_LP)
      rd_d = {4'h0, lp_busy[2], lp_ulps[2], lp_busy[1], lp_ulps[1]};
    if (addr_i == txc_pkg::A_STATUS)
      rd_d = {6'h00, stat_q};
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? rd_d : 8'h00;
  end

  // --------------------------------------------------------------
  // command status, write one to clear, set wins
  // --------------------------------------------------------------
  wire [1:0] cmd_ev = {cci_wr_cmd_i, cci_rd_cmd_i};
  wire [1:0] stat_d = cmd_ev | (stat_q & ~(wr_stat ? wdata_i[1:0] : 2'b00));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stat_q <= 2'b00;
      cmd_irq_o <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      cmd_irq_o <= |(stat_d & irq_en);
    end
  end

  // --------------------------------------------------------------
  // byte clock and escape clock ticks
  // --------------------------------------------------------------
  logic [15:0] div_q;
  logic esc_s1_q, esc_s2_q, esc_s3_q;
  wire byte_tick = div_q == 16'(BYTE_DIV - 1);
  // the second and third stages feed the edge detector
  wire esc_tick = esc_s2_q && !esc_s3_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q <= 16'h0000;
      esc_s1_q <= 1'b0;
      esc_s2_q <= 1'b0;
      esc_s3_q <= 1'b0;
    end
    else
    begin
      div_q <= byte_tick ? 16'h0000 : div_q + 16'h0001;
      esc_s1_q <= esc_clk_i;
      esc_s2_q <= esc_s1_q;
      esc_s3_q <= esc_s2_q;
    end
  end

  // --------------------------------------------------------------
  // lane low-power control
  // --------------------------------------------------------------
  wire [2:0] lp_enter = {wr_dat_lp & wdata_i[txc_pkg::LP_LANE_STRIDE + txc_pkg::B_LP_ENTER],
                         wr_dat_lp & wdata_i[txc_pkg::B_LP_ENTER],
                         wr_clk_lp & wdata_i[txc_pkg::B_LP_ENTER]};
  wire [2:0] lp_exit = {wr_dat_lp & wdata_i[txc_pkg::LP_LANE_STRIDE + txc_pkg::B_LP_EXIT],
                        wr_dat_lp & wdata_i[txc_pkg::B_LP_EXIT],
                        wr_clk_lp & wdata_i[txc_pkg::B_LP_EXIT]};

  for (genvar l = 0; l < txc_pkg::N_LANES; l++)
  begin : g_lane
    lp_lane u_lane (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enter_i(lp_enter[l]),
      .exit_i(lp_exit[l]),
      .esc_tick_i(esc_tick),
      .twake_i(twake),
      .esc_req_o(esc_req_o[l]),
      .ulps_o(lp_ulps[l]),
      .busy_o(lp_busy[l])
    );
  end

  // lane flops drive the pins directly
  assign ulps_o = lp_ulps;

  // --------------------------------------------------------------
  // video timing, polarity normalised
  // --------------------------------------------------------------
  wire de_act = de_i ^ pol[txc_pkg::B_POL_DE];
  wire hs_act = hsync_i ^ pol[txc_pkg::B_POL_HS];
  wire vs_act = vsync_i ^ pol[txc_pkg::B_POL_VS];
  logic hs_q, vs_q;
  wire frame_edge = vs_act && !vs_q;
  wire blank_edge = !vs_act && vs_q;
  wire line_edge = hs_act && !hs_q && vs_act;

  // --------------------------------------------------------------
  // start-up sequencer and skew calibration
  // --------------------------------------------------------------
  txc_pkg::seq_state_t st_q, st_d;
  logic [15:0] init_cnt_q;
  logic [15:0] sk_cnt_q, sk_cnt_d;

  always_comb
  begin
    st_d = st_q;
    sk_cnt_d = sk_cnt_q;
    if (byte_tick && sk_cnt_q != 16'h0000)
      sk_cnt_d = sk_cnt_q - 16'h0001;
    case (st_q)
      txc_pkg::S_INIT:
        if (byte_tick && init_cnt_q >= init_period)
          st_d = txc_pkg::S_RDY;
      txc_pkg::S_RDY:
        if (ready)
        begin
          st_d = iskew_en ? txc_pkg::S_ISKEW : txc_pkg::S_RUN;
          sk_cnt_d = iskew_en ? iskew_len : 16'h0000;
        end
      txc_pkg::S_ISKEW:
        if (sk_cnt_q == 16'h0000)
          st_d = txc_pkg::S_RUN;
      txc_pkg::S_RUN:
      begin
        if (!ready)
        begin
          st_d = txc_pkg::S_RDY;
          sk_cnt_d = 16'h0000;
        end
        else if (vs_act)
          sk_cnt_d = 16'h0000; // pattern never overlaps a frame
        else if (blank_edge && pskew_en)
          sk_cnt_d = {4'h0, pskew_len};
      end
      default: st_d = txc_pkg::S_INIT;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= txc_pkg::S_INIT;
      init_cnt_q <= 16'h0000;
      sk_cnt_q <= 16'h0000;
      hs_clk_req_o <= 1'b0;
      xfer_en_o <= 1'b0;
      skew_req_o <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (st_q == txc_pkg::S_INIT && byte_tick && init_cnt_q < init_period)
        init_cnt_q <= init_cnt_q + 16'h0001;
      sk_cnt_q <= sk_cnt_d;
      hs_clk_req_o <= st_d != txc_pkg::S_INIT;
      xfer_en_o <= (st_d == txc_pkg::S_RUN) && !(|lp_busy);
      skew_req_o <= sk_cnt_d != 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // static settings towards the packet path
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_fmt_o <= 1'b0;
      emb_fmt_o <= 1'b0;
      two_lane_o <= 1'b0;
      clk_noncont_o <= 1'b0;
      scramble_o <= 1'b0;
    end
    else
    begin
      frame_fmt_o <= regs_q[txc_pkg::R_FMT][txc_pkg::B_FMT_FRAME];
      emb_fmt_o <= regs_q[txc_pkg::R_FMT][txc_pkg::B_FMT_EMB];
      two_lane_o <= regs_q[txc_pkg::R_LANE][txc_pkg::B_LANE2];
      clk_noncont_o <= regs_q[txc_pkg::R_CLKMODE][txc_pkg::B_NONCONT];
      scramble_o <= regs_q[txc_pkg::R_SCRAM][txc_pkg::B_ENABLE];
    end
  end

  // --------------------------------------------------------------
  // frame and line numbering
  // --------------------------------------------------------------
  logic [3:0] ln_slot;
  logic ln_hit;
  logic [15:0] lc_q [txc_pkg::N_LN];
  wire [15:0] fn_next = (frame_num_o >= fn_limit) ? 16'h0001 : frame_num_o + 16'h0001;
  wire ln_on = ln_hit && ln_en[ln_slot];

  always_comb
  begin
    ln_hit = 1'b1;
    ln_slot = 4'h0;
    if (dtype_i >= txc_pkg::DT_RAW8 && dtype_i <= txc_pkg::DT_RAW12)
      ln_slot = 4'(dtype_i - txc_pkg::DT_RAW8);
    else if (dtype_i >= txc_pkg::DT_UDT1 && dtype_i <= txc_pkg::DT_UDT8)
      ln_slot = 4'(dtype_i - txc_pkg::DT_UDT1) + txc_pkg::LN_UDT_BASE;
    else if (dtype_i == txc_pkg::DT_EMB)
      ln_slot = txc_pkg::LN_EMB_SLOT;
    else
      ln_hit = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      frame_start_o <= 1'b0;
      frame_num_o <= 16'h0000;
      line_start_o <= 1'b0;
      line_num_o <= 16'h0000;
      line_num_en_o <= 1'b0;
      pix_valid_o <= 1'b0;
      for (int i = 0; i < txc_pkg::N_LN; i++)
        lc_q[i] <= 16'h0000;
    end
    else
    begin
      hs_q <= hs_act;
      vs_q <= vs_act;
      frame_start_o <= frame_edge && xfer_en_o;
      line_start_o <= line_edge && xfer_en_o;
      pix_valid_o <= de_act && vs_act && xfer_en_o;
      if (fn_limit == 16'h0000)
        frame_num_o <= 16'h0000;
      else if (frame_edge && xfer_en_o)
        frame_num_o <= fn_next;
      if (frame_edge)
        for (int i = 0; i < txc_pkg::N_LN; i++)
          lc_q[i] <= 16'h0000;
      else if (line_edge && xfer_en_o && ln_on)
        lc_q[ln_slot] <= lc_q[ln_slot] + 16'h0001;
      if (line_edge && xfer_en_o)
      begin
        line_num_en_o <= ln_on;
        line_num_o <= ln_on ? lc_q[ln_slot] + 16'h0001 : 16'h0000;
      end
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  sequence s_cmd_seen;
    cci_rd_cmd_i ##1 stat_q[txc_pkg::B_CMD_RD];
  endsequence

  property p_init_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(hs_clk_req_o) |-> $past(init_cnt_q) >= $past(init_period);
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("clock request early");

  property p_ready_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    xfer_en_o |-> $past(ready);
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("transfer without ready");

  property p_fmt;
    @(posedge clk_i) disable iff (!rst_n_i)
    $changed(regs_q[txc_pkg::R_FMT]) |=>
      frame_fmt_o == $past(regs_q[txc_pkg::R_FMT][txc_pkg::B_FMT_FRAME], 1);
  endproperty
  a_fmt: assert property (p_fmt) else $error("frame format not followed");

  property p_fn_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
    (frame_edge && xfer_en_o && fn_limit != 16'h0000 && frame_num_o >= fn_limit)
      |=> frame_num_o == 16'h0001;
  endproperty
  a_fn_wrap: assert property (p_fn_wrap) else $error("frame number did not wrap");

  property p_fn_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    (fn_limit == 16'h0000) ##1 (fn_limit == 16'h0000) |-> frame_num_o == 16'h0000;
  endproperty
  a_fn_off: assert property (p_fn_off) else $error("frame number not disabled");

  property p_status_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    cci_rd_cmd_i |-> s_cmd_seen;
  endproperty
  a_status_set: assert property (p_status_set) else $error("read status lost");

  property p_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    (cci_wr_cmd_i && irq_en[txc_pkg::B_CMD_WR]) |=> cmd_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("command interrupt missing");

  property p_iskew;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_q == txc_pkg::S_ISKEW && sk_cnt_q > 16'h0001) |=> skew_req_o;
  endproperty
  a_iskew: assert property (p_iskew) else $error("initial skew dropped");

  property p_pskew_blank;
    @(posedge clk_i) disable iff (!rst_n_i)
    (skew_req_o && st_q == txc_pkg::S_RUN) |-> !$past(vs_act);
  endproperty
  a_pskew_blank: assert property (p_pskew_blank) else $error("skew inside frame");

endmodule

// ===== tb/video_src.sv
// sensor-side stand-in: video timing source and free-running escape clock
`timescale 1ns/1ps
module video_src (
  input wire logic clk_i,
  input wire logic [2:0] inv_i,
  output logic esc_clk_o,
  output logic de_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic [5:0] dtype_o
);
  // act bits: vsync, hsync, data enable
  logic [2:0] act = 3'b000;
  initial esc_clk_o = 1'b0;
  initial dtype_o = 6'h00;
  always #80 esc_clk_o = ~esc_clk_o;
  // idle level follows the programmed polarity, so an inverted pin idles high
  assign {vsync_o, hsync_o, de_o} = act ^ inv_i;
  task frame(input int lines, input logic [5:0] dt);
    @(posedge clk_i);
    dtype_o <= dt;
    act <= 3'b100;
    repeat (lines)
    begin
      repeat (4) @(posedge clk_i);
      act <= 3'b111;
      repeat (8) @(posedge clk_i);
      act <= 3'b100;
    end
    repeat (4) @(posedge clk_i);
    act <= 3'b000;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the transmit controller configuration block
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic crd = 1'b0;
  logic cwr = 1'b0;
  logic [2:0] inv = 3'b000;
  logic esc, de, hs, vs, hs_req, xfer, ffmt, efmt, two, nc, scr, skew, irq;
  logic [5:0] dt;
  logic [7:0] rdata, r;
  logic [15:0] fnum, lnum;
  logic [2:0] esc_req, ulps;
  logic fst, lst, lne, pv;
  int fs_n = 0;
  int ls_n = 0;
  int pv_n = 0;
  logic [5:0] dts [4] = '{6'h2b, 6'h37, 6'h30, 6'h12};
  int fail_count = 0;
  int cmp_count = 0;
  int skew_n = 0;
  int n0;

  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (skew === 1'b1)
      skew_n <= skew_n + 1;
  // pulse and valid counters for the packet path outputs
  always @(posedge clk_i)
  begin
    if (fst === 1'b1)
      fs_n <= fs_n + 1;
    if (lst === 1'b1)
      ls_n <= ls_n + 1;
    if (pv === 1'b1)
      pv_n <= pv_n + 1;
  end

  video_src src (.clk_i(clk_i), .inv_i(inv), .esc_clk_o(esc), .de_o(de), .hsync_o(hs),
    .vsync_o(vs), .dtype_o(dt));
  csi_tx_config #(.BYTE_DIV(1)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .esc_clk_i(esc),
    .de_i(de), .hsync_i(hs), .vsync_i(vs), .dtype_i(dt), .cci_rd_cmd_i(crd),
    .cci_wr_cmd_i(cwr), .hs_clk_req_o(hs_req), .xfer_en_o(xfer), .frame_fmt_o(ffmt),
    .emb_fmt_o(efmt), .two_lane_o(two), .clk_noncont_o(nc), .scramble_o(scr),
    .frame_start_o(fst), .frame_num_o(fnum), .line_start_o(lst), .line_num_o(lnum),
    .line_num_en_o(lne), .pix_valid_o(pv), .skew_req_o(skew), .esc_req_o(esc_req),
    .ulps_o(ulps), .cmd_irq_o(irq));

  // ----------
  // bus tasks
  // ----------
  // every task that waits on the clock returns 1 ns after an edge so that edge's updates have landed
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    tick(1);
  endtask
  task rd(input logic [15:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    r = rdata;
    tick(1);
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task rchk(input logic [15:0] a, input logic [7:0] exp);
    rd(a);
    chk({8'h00, r}, {8'h00, exp});
  endtask
  task cmd(input logic w);
    cwr <= w;
    crd <= ~w;
    tick(1);
    cwr <= 1'b0;
    crd <= 1'b0;
  endtask
  task done(input string s);
    $display("%s test done", s);
  endtask
  task give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------
  // tests
  // ----------
  // the whole sequence needs about 1500 cycles; 60 us leaves wide margin
  initial
  begin
    #60us;
    fail_count++;
    give_verdict();
  end

  initial
  begin
    tick(16);
    rst_n_i <= 1'b1;
    tick(8);
    chk(16'(hs_req), 16'h0000);
    tick(72);
    chk(16'(hs_req), 16'h0001);
    rchk(16'h6000, 8'h00);
    for (int i = 0; i < txc_pkg::NREG; i++)
    begin
      rchk(txc_pkg::REG_ADDR[i], txc_pkg::REG_RST[i]);
      wr(txc_pkg::REG_ADDR[i], 8'hff);
      rchk(txc_pkg::REG_ADDR[i], txc_pkg::REG_MASK[i]);
      wr(txc_pkg::REG_ADDR[i], txc_pkg::REG_RST[i]);
    end
    done("registers");
    // controller reset ahead of the polarity setting; init period restarts
    rst_n_i <= 1'b0;
    tick(4);
    rst_n_i <= 1'b1;
    tick(2);
    chk(16'(hs_req), 16'h0000);
    tick(70);
    chk(16'(hs_req), 16'h0001);
    wr(16'h6003, 8'h01);
    wr(16'h6005, 8'h0a);
    wr(16'h6010, 8'h03);
    wr(16'h6011, 8'h04);
    inv <= 3'b100;
    wr(16'h6012, 8'h01);
    wr(16'h6013, 8'h01);
    wr(16'h6017, 8'h03);
    wr(16'h601f, 8'h01);
    wr(16'h6037, 8'h01);
    wr(16'h6066, 8'h04);
    chk(16'(xfer), 16'h0000);
    n0 = skew_n;
    wr(16'h6006, 8'h01);
    tick(40);
    chk(16'(skew_n - n0), 16'h000a);
    chk(16'(xfer), 16'h0001);
    chk(16'({ffmt, efmt, two, nc, scr}), 16'h001f);
    done("startup");
    for (int f = 0; f < 4; f++)
    begin
      src.frame(3, 6'h2a);
      chk(fnum, 16'(f % 3 + 1));
      chk(lnum, 16'h0003);
    end
    chk(16'(fs_n), 16'h0004);
    chk(16'(ls_n), 16'h000c);
    chk(16'(pv_n), 16'h0060);
    wr(16'h6038, 8'h80);
    wr(16'h6039, 8'h01);
    foreach (dts[i])
    begin
      src.frame(2, dts[i]);
      chk(lnum, (i % 2) ? 16'h0002 : 16'h0000);
      chk(16'(lne), 16'(i % 2));
    end
    wr(16'h601d, 8'h01);
    wr(16'h601e, 8'h02);
    wr(16'h601c, 8'h01);
    wr(16'h6017, 8'h00);
    n0 = skew_n;
    src.frame(1, 6'h2a);
    tick(300);
    chk(fnum, 16'h0000);
    chk(16'(skew_n - n0), 16'h0102);
    wr(16'h601c, 8'h00);
    done("frames");
    wr(16'h6014, 8'h01);
    chk(16'({ulps, esc_req}), 16'h0009);
    rd(16'h6014);
    chk(16'(r[0]), 16'h0001);
    wr(16'h6014, 8'h02);
    tick(50);
    chk(16'({ulps, esc_req}), 16'h0001);
    tick(100);
    chk(16'(esc_req), 16'h0000);
    wr(16'h6015, 8'h05);
    chk(16'({ulps, esc_req, xfer}), 16'h006c);
    wr(16'h6015, 8'h0a);
    tick(160);
    chk(16'({ulps, esc_req, xfer}), 16'h0001);
    done("lowpower");
    cmd(1'b0);
    rchk(16'h6019, 8'h01);
    chk(16'(irq), 16'h0000);
    // write-command enable alone must not pass the pending read status
    wr(16'h6018, 8'h02);
    chk(16'(irq), 16'h0000);
    wr(16'h6018, 8'h03);
    chk(16'(irq), 16'h0001);
    cmd(1'b1);
    rchk(16'h6019, 8'h03);
    wr(16'h6019, 8'h03);
    rchk(16'h6019, 8'h00);
    chk(16'(irq), 16'h0000);
    done("commands");
    give_verdict();
  end
endmodule
